// [hw/lpmc_defines.svh]
// Register map, field positions, reset values and timing of the controller
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// Register byte offsets
`define LPMC_OFF_STBY      8'h00
`define LPMC_OFF_MSTPA     8'h04
`define LPMC_OFF_MSTPB     8'h08
`define LPMC_OFF_MSTPC     8'h0c
`define LPMC_OFF_OPC       8'h10
`define LPMC_OFF_CLKDIV    8'h14
`define LPMC_OFF_STATUS    8'h18

// Field positions
`define LPMC_BIT_SSEL      15
`define LPMC_BIT_DEEPEN    31
`define LPMC_BIT_TFLAG     4
`define LPMC_BIT_FRONTEND  16
`define LPMC_BIT_SARADC    17
`define LPMC_BIT_SDAD0     25
`define LPMC_BIT_SDAD1     26
`define LPMC_BIT_CAN       0
`define LPMC_BIT_XSERIAL   4

// Operating power control mode codes
`define LPMC_OPC_HIGH      3'h0
`define LPMC_OPC_MIDDLE    3'h2

// Reset values
`define LPMC_RST_STBY      16'h0000
`define LPMC_RST_MSTP      32'hffff_ffff
`define LPMC_RST_MSTPC     32'h7fff_ffff
`define LPMC_RST_CLKDIV    20'h0_0000

// Timing
`define LPMC_CLK_PERIOD_NS 50
`define LPMC_OPC_SETTLE_NS 1000
`define LPMC_OSC_WAKE_NS   2000

// Bus responses
`define LPMC_RESP_OKAY     2'h0
`define LPMC_RESP_SLVERR   2'h2

`endif

// [hw/lpmc_pkg.sv]
// Types shared by the low-power mode controller
package lpmc_pkg;

	// Low-power sequencing states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_SLEEP,
		ST_DEEP,
		ST_STBY,
		ST_WAKE
	} lpmc_state_type;

	// Number of independently divided clock enables
	localparam int LPMC_NUM_DIV = 5;

endpackage

// [hw/lpmc_top.sv]
// Low-power mode controller with AXI4-Lite register slave
// How it works
// - Wait with standby select 0 enters sleep or deep sleep; with 1, standby.
// - Deep-sleep enable bit in third stop register picks deep sleep.
// - Mode field codes: 000 high speed, 010 middle speed; others refused.
// - Transition flag reads 1 while a mode change runs, 0 when done.
// - Sleep and standby are left on interrupt or reset.
// - Wake by interrupt resumes the CPU into interrupt processing.
// - Stopped units keep their register state and resume from it.
// - Units follow their own stop bits in sleep and deep sleep; standby stops them all.
// - RAM runs in sleep, stops with contents retained in standby.
// - Independent watchdog and its oscillator stay enabled in all modes.
// - Voltage detector, low-power timer and power-on reset stay enabled.
// - Timers run in sleep; timers, DMA, transfer, flash stop in standby.
// - Each peripheral stops on its own module stop bit.
// - Stop A bits 16,17,25,26: front end, converter, two sigma-deltas.
// - Stop B bit 0 stops CAN, bit 4 the extra serial unit.
// - Five clocks get independent division ratios.
// - Chosen power mode applies in run, sleep and deep sleep.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "lpmc_defines.svh"

module lpmc_top
	import lpmc_pkg::*;
#(
	parameter int DIV_W = 4
)
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	// AXI4-Lite write
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// CPU and interrupt side
	input  wire logic                    waitExec,
	input  wire logic                    wakeIrq,
	output logic                         resumeIrq,
	output logic                         cpuClkEn,
	// Gating outputs
	output logic                         ramClkEn,
	output logic                         busMasterStop,
	output logic                         flashStop,
	output logic                         timerStop,
	output logic [31:0]                  moduleStopA,
	output logic [31:0]                  moduleStopB,
	output logic [31:0]                  moduleStopC,
	output logic [4:0]                   oscEn,
	output logic                         alwaysOnEn,
	output logic [2:0]                   powerMode,
	output logic [LPMC_NUM_DIV-1:0]      clkEnPulse
);
	////////////////////////////////////////////////////////////////////////
	// Derived timing, rounded up to whole cycles
	localparam logic [15:0] OPC_CYC = 16'((`LPMC_OPC_SETTLE_NS
		+ `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS);
	localparam logic [15:0] OSC_CYC = 16'((`LPMC_OSC_WAKE_NS
		+ `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS);
	localparam int OPC_BOUND = OPC_CYC + 1;
	localparam int OSC_BOUND = OSC_CYC + 1;
	localparam int DIVF = LPMC_NUM_DIV * DIV_W;
	// Divider fields must fit one register word
	if (DIV_W < 1 || DIVF > 32)
	begin : g_bad_div
		$error("DIV_W out of range");
	end
	////////////////////////////////////////////////////////////////////////
	// Whole state of the block
	typedef struct packed {
		lpmc_state_type                   st;
		logic [15:0]                      cnt;
		logic [15:0]                      stbyCtl;
		logic [31:0]                      stopA;
		logic [31:0]                      stopB;
		logic [31:0]                      stopC;
		logic [2:0]                       opcMode;
		logic [2:0]                       opcTarget;
		logic                             tFlag;
		logic [15:0]                      opcCnt;
		logic [DIVF-1:0]                  divRatio;
		logic [LPMC_NUM_DIV-1:0][DIV_W-1:0] divCnt;
		logic [LPMC_NUM_DIV-1:0]          divPulse;
		logic                             awHeld;
		logic [7:0]                       awAddr;
		logic                             wHeld;
		logic [31:0]                      wData;
		logic [3:0]                       wStrb;
		logic                             awReady;
		logic                             wReady;
		logic                             bValid;
		logic [1:0]                       bResp;
		logic                             arReady;
		logic                             rValid;
		logic [31:0]                      rData;
		logic [1:0]                       rResp;
		logic                             resume;
		logic                             cpuEn;
		logic                             ramEn;
		logic                             bmStop;
		logic                             flStop;
		logic                             tmStop;
		logic [31:0]                      mA;
		logic [31:0]                      mB;
		logic [31:0]                      mC;
		logic [4:0]                       osc;
		logic                             aon;
	} lpmc_regs_type;
	lpmc_regs_type r;
	lpmc_regs_type next_r;
	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] stb);
		logic [31:0] res;
		for (int i = 0; i < 4; i++)
			res[i*8 +: 8] = stb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
		return res;
	endfunction
	// Read mux; unmapped addresses answer an error
	function automatic logic [32:0] readReg(input lpmc_regs_type q,
		input logic [7:0] a);
		unique case (a)
			`LPMC_OFF_STBY:   readReg = {1'b1, 16'h0000, q.stbyCtl};
			`LPMC_OFF_MSTPA:  readReg = {1'b1, q.stopA};
			`LPMC_OFF_MSTPB:  readReg = {1'b1, q.stopB};
			`LPMC_OFF_MSTPC:  readReg = {1'b1, q.stopC};
			`LPMC_OFF_OPC:    readReg = {1'b1, 24'h00_0000, 3'h0, q.tFlag,
				1'b0, q.opcMode};
			`LPMC_OFF_CLKDIV: readReg = {1'b1, 32'(q.divRatio)};
			`LPMC_OFF_STATUS: readReg = {1'b1, 29'h0000_0000, q.st};
			default:          readReg = {1'b0, 32'h0000_0000};
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		logic [32:0] rd;
		logic [31:0] wv;
		logic        doWr;
		logic        stby;
		rd = 33'h0_0000_0000;
		wv = 32'h0000_0000;
		doWr = 1'b0;
		stby = 1'b0;
		next_r = r;
		next_r.resume = 1'b0;
		// Write channels are taken in either order and held
		if (s_axi_awvalid && r.awReady)
		begin
			next_r.awHeld = 1'b1;
			next_r.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wReady)
		begin
			next_r.wHeld = 1'b1;
			next_r.wData = s_axi_wdata;
			next_r.wStrb = s_axi_wstrb;
		end
		if (r.bValid && s_axi_bready)
			next_r.bValid = 1'b0;
		if (r.awHeld && r.wHeld && !r.bValid)
		begin
			doWr = 1'b1;
			next_r.awHeld = 1'b0;
			next_r.wHeld = 1'b0;
			next_r.bValid = 1'b1;
			rd = readReg(r, r.awAddr);
			next_r.bResp = rd[32] ? `LPMC_RESP_OKAY : `LPMC_RESP_SLVERR;
			wv = merge(rd[31:0], r.wData, r.wStrb);
		end
		// registers keep their values; writes steer gating, dividers and power mode
		if (doWr)
		begin
			unique case (r.awAddr)
				`LPMC_OFF_STBY:   next_r.stbyCtl = wv[15:0];
				`LPMC_OFF_MSTPA:  next_r.stopA = wv;
				`LPMC_OFF_MSTPB:  next_r.stopB = wv;
				`LPMC_OFF_MSTPC:  next_r.stopC = wv;
				`LPMC_OFF_CLKDIV: next_r.divRatio = wv[DIVF-1:0];
				`LPMC_OFF_OPC:
				begin
					if ((wv[2:0] == `LPMC_OPC_HIGH ||
						wv[2:0] == `LPMC_OPC_MIDDLE) &&
						wv[2:0] != r.opcMode && !r.tFlag)
					begin
						next_r.opcTarget = wv[2:0];
						next_r.tFlag = 1'b1;
						next_r.opcCnt = OPC_CYC;
					end
				end
				default: ;
			endcase
		end
		// settle count, then the new mode takes effect
		if (r.tFlag)
		begin
			next_r.opcCnt = r.opcCnt - 16'h0001;
			if (r.opcCnt == 16'h0001)
			begin
				next_r.tFlag = 1'b0;
				next_r.opcMode = r.opcTarget;
			end
		end
		// Read channel: one read at a time
		if (s_axi_arvalid && r.arReady)
		begin
			rd = readReg(r, s_axi_araddr);
			next_r.rValid = 1'b1;
			next_r.rData = rd[31:0];
			next_r.rResp = rd[32] ? `LPMC_RESP_OKAY : `LPMC_RESP_SLVERR;
		end
		else if (r.rValid && s_axi_rready)
			next_r.rValid = 1'b0;
		next_r.arReady = !next_r.rValid && !(s_axi_arvalid && r.arReady);
		next_r.awReady = !next_r.awHeld && !next_r.bValid;
		next_r.wReady = !next_r.wHeld && !next_r.bValid;
		// Sequencer
		unique case (r.st)
			ST_RUN:
			begin
				if (waitExec)
				begin
					if (r.stbyCtl[`LPMC_BIT_SSEL])
						next_r.st = ST_STBY;
					else if (r.stopC[`LPMC_BIT_DEEPEN])
						next_r.st = ST_DEEP;
					else
						next_r.st = ST_SLEEP;
				end
			end
			ST_SLEEP, ST_DEEP:
			begin
				if (wakeIrq)
				begin
					next_r.st = ST_RUN;
					next_r.resume = 1'b1;
				end
			end
			ST_STBY:
			begin
				// restart oscillators, wait for them to settle
				if (wakeIrq)
				begin
					next_r.st = ST_WAKE;
					next_r.cnt = OSC_CYC;
				end
			end
			ST_WAKE:
			begin
				next_r.cnt = r.cnt - 16'h0001;
				if (r.cnt == 16'h0001)
				begin
					next_r.st = ST_RUN;
					next_r.resume = 1'b1;
				end
			end
		endcase
		// independent dividers, ratio field plus one
		for (int i = 0; i < LPMC_NUM_DIV; i++)
		begin
			next_r.divPulse[i] = 1'b0;
			if (r.divCnt[i] >= r.divRatio[i*DIV_W +: DIV_W])
			begin
				next_r.divCnt[i] = '0;
				next_r.divPulse[i] = 1'b1;
			end
			else
				next_r.divCnt[i] = r.divCnt[i] + DIV_W'(1);
		end
		// Gating outputs follow the coming state
		stby = (next_r.st == ST_STBY) || (next_r.st == ST_WAKE);
		next_r.cpuEn = (next_r.st == ST_RUN);
		// RAM runs in sleep, held in standby
		next_r.ramEn = !stby;
		// DMA and transfer controllers stop in standby
		next_r.bmStop = stby;
		next_r.flStop = stby;
		next_r.tmStop = stby;
		// own stop bits, all forced in standby
		next_r.mA = next_r.stopA | {32{stby}};
		next_r.mB = next_r.stopB | {32{stby}};
		next_r.mC = next_r.stopC | {32{stby}};
		// oscillators off only while in standby proper
		next_r.osc = (next_r.st == ST_STBY) ? 5'h00 : 5'h1f;
		// watchdog and its oscillator gated only while reset is held
		next_r.aon = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.st <= ST_RUN;
			r.stbyCtl <= `LPMC_RST_STBY;
			r.stopA <= `LPMC_RST_MSTP;
			r.stopB <= `LPMC_RST_MSTP;
			r.stopC <= `LPMC_RST_MSTPC;
			r.opcMode <= `LPMC_OPC_HIGH;
			r.divRatio <= DIVF'(`LPMC_RST_CLKDIV);
			r.cpuEn <= 1'b1;
			r.ramEn <= 1'b1;
			r.mA <= `LPMC_RST_MSTP;
			r.mB <= `LPMC_RST_MSTP;
			r.mC <= `LPMC_RST_MSTPC;
			r.osc <= 5'h1f;
		end
		else
			r <= next_r;
	end
	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign s_axi_awready = r.awReady;
	assign s_axi_wready  = r.wReady;
	assign s_axi_bvalid  = r.bValid;
	assign s_axi_bresp   = r.bResp;
	assign s_axi_arready = r.arReady;
	assign s_axi_rvalid  = r.rValid;
	assign s_axi_rdata   = r.rData;
	assign s_axi_rresp   = r.rResp;
	assign resumeIrq     = r.resume;
	assign cpuClkEn      = r.cpuEn;
	assign ramClkEn      = r.ramEn;
	assign busMasterStop = r.bmStop;
	assign flashStop     = r.flStop;
	assign timerStop     = r.tmStop;
	assign moduleStopA   = r.mA;
	assign moduleStopB   = r.mB;
	assign moduleStopC   = r.mC;
	assign oscEn         = r.osc;
	// detector, timer and reset circuits share the always-on enable
	assign alwaysOnEn    = r.aon;
	// mode applies whatever the sleep state
	assign powerMode     = r.opcMode;
	assign clkEnPulse    = r.divPulse;
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_waitStby;
		r.st == ST_RUN && waitExec && r.stbyCtl[`LPMC_BIT_SSEL];
	endsequence
	sequence s_waitDeep;
		r.st == ST_RUN && waitExec && !r.stbyCtl[`LPMC_BIT_SSEL]
			&& r.stopC[`LPMC_BIT_DEEPEN];
	endsequence
	sequence s_stbyWake;
		r.st == ST_STBY && wakeIrq;
	endsequence
	a_standby_entry: assert property (s_waitStby |=>
		r.st == ST_STBY && oscEn == 5'h00 && !ramClkEn)
		else $error("standby not entered");
	a_deep_entry: assert property (s_waitDeep |=> r.st == ST_DEEP
		&& !cpuClkEn && ramClkEn) else $error("deep sleep not entered");
	a_mode_legal: assert property (powerMode == `LPMC_OPC_HIGH
		|| powerMode == `LPMC_OPC_MIDDLE) else $error("illegal mode");
	a_flag_clears: assert property ($rose(r.tFlag) |-> r.tFlag[*8]
		##[1:OPC_BOUND] ($fell(r.tFlag) && powerMode == r.opcTarget))
		else $error("mode change timing wrong");
	a_sleep_wake: assert property ((r.st == ST_SLEEP
		|| r.st == ST_DEEP) && wakeIrq |=> resumeIrq && cpuClkEn)
		else $error("sleep wake missed");
	a_stby_resume: assert property (s_stbyWake |=> oscEn == 5'h1f
		##[1:OSC_BOUND] resumeIrq) else $error("standby wake missed");
	a_stop_follow: assert property (r.st != ST_STBY
		&& r.st != ST_WAKE |-> moduleStopA == r.stopA
		&& moduleStopB == r.stopB) else $error("module stop mismatch");
	a_always_on: assert property ($past(reset_n) |-> alwaysOnEn)
		else $error("always-on enable dropped");
endmodule // lpmc_top

// [test/lpmc_cpu_model.sv]
// CPU core model: issues the wait instruction and raises interrupts
`timescale 1ns/10ps

module lpmc_cpu_model
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Commands from the bench
	input  wire logic doWait,
	input  wire logic doIrq,
	// Controller side
	input  wire logic resumeIrq,
	output logic      waitExec,
	output logic      wakeIrq
);
	////////////////////////////////////////////////////////////////////////
	// Entry by instruction, exit by interrupt
	// Interrupt stays pending until the core is handed it, so a slow
	// controller cannot lose the wake request
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			waitExec <= 1'b0;
			wakeIrq  <= 1'b0;
		end
		else
		begin
			waitExec <= doWait;
			if (resumeIrq)
				wakeIrq <= 1'b0;
			else if (doIrq)
				wakeIrq <= 1'b1;
		end
	end
endmodule // lpmc_cpu_model

// [test/tb_top.sv]
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`include "lpmc_defines.svh"

module tb_top import lpmc_pkg::*;;
	typedef struct packed {
		logic        we;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} lpmc_row_type;
	localparam logic [1:0] OK = `LPMC_RESP_OKAY;
	localparam logic [1:0] SE = `LPMC_RESP_SLVERR;
	// Reset values first, then writes read back, then an unmapped slot
	localparam lpmc_row_type ROWS [12] = '{
		'{1'b0, `LPMC_OFF_STBY, 32'h0, 32'h0, OK},
		'{1'b0, `LPMC_OFF_MSTPA, 32'h0, `LPMC_RST_MSTP, OK},
		'{1'b0, `LPMC_OFF_MSTPB, 32'h0, `LPMC_RST_MSTP, OK},
		'{1'b0, `LPMC_OFF_MSTPC, 32'h0, `LPMC_RST_MSTPC, OK},
		'{1'b0, `LPMC_OFF_OPC, 32'h0, 32'h0, OK},
		'{1'b0, `LPMC_OFF_CLKDIV, 32'h0, 32'h0, OK},
		'{1'b0, `LPMC_OFF_STATUS, 32'h0, 32'h0, OK},
		'{1'b1, `LPMC_OFF_STBY, 32'h8000, 32'h8000, OK},
		'{1'b1, `LPMC_OFF_MSTPA, 32'hf9fc_ffff, 32'hf9fc_ffff, OK},
		'{1'b1, `LPMC_OFF_MSTPB, 32'hffff_ffee, 32'hffff_ffee, OK},
		'{1'b1, 8'h1c, 32'h1, 32'h0, SE},
		'{1'b0, 8'h1c, 32'h0, 32'h0, SE}};

	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, got, stopA, stopB, stopC;
	logic        doWait = 1'b0, doIrq = 1'b0;
	logic        waitExec, wakeIrq, resumeIrq, cpuClkEn, ramClkEn;
	logic        busStop, flashStop, timerStop, alwaysOnEn;
	logic [4:0]  oscEn, clkEn;
	logic [2:0]  powerMode;
	int          errors = 0, compares = 0, n, c0, c1, c2;

	lpmc_top lpmc_top_i (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.waitExec(waitExec), .wakeIrq(wakeIrq), .resumeIrq(resumeIrq),
		.cpuClkEn(cpuClkEn), .ramClkEn(ramClkEn), .busMasterStop(busStop),
		.flashStop(flashStop), .timerStop(timerStop),
		.moduleStopA(stopA), .moduleStopB(stopB), .moduleStopC(stopC),
		.oscEn(oscEn), .alwaysOnEn(alwaysOnEn), .powerMode(powerMode),
		.clkEnPulse(clkEn));

	lpmc_cpu_model lpmc_cpu_model_i (
		.clk_sys(clk_sys), .reset_n(reset_n), .doWait(doWait),
		.doIrq(doIrq), .resumeIrq(resumeIrq), .waitExec(waitExec),
		.wakeIrq(wakeIrq));

	////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Bus write: both channels offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && k < 100);
		chk(k < 100, 1'b1, "write answer");
		resp = bresp;
		bready <= 1'b0;
	endtask

	// Bus read: data and response taken at the rvalid edge
	task automatic axr(input logic [7:0] a);
		int k;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && k < 100);
		chk(k < 100, 1'b1, "read answer");
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// Program the mode, execute wait, confirm the reported state
	task automatic enter(input logic [31:0] sb, input logic [31:0] mc,
		input logic [31:0] st);
		axw(`LPMC_OFF_STBY, sb);
		axw(`LPMC_OFF_MSTPC, mc);
		axr(`LPMC_OFF_OPC);
		chk(got[`LPMC_BIT_TFLAG], 1'b0, "flag idle before wait");
		@(posedge clk_sys);
		doWait <= 1'b1;
		@(posedge clk_sys);
		doWait <= 1'b0;
		repeat (3) @(posedge clk_sys);
		axr(`LPMC_OFF_STATUS);
		chk(got, st, "state after wait");
		chk(cpuClkEn, 1'b0, "cpu clock gated");
	endtask

	// Raise an interrupt and count cycles until the core is resumed
	task automatic wake;
		@(posedge clk_sys);
		doIrq <= 1'b1;
		@(posedge clk_sys);
		doIrq <= 1'b0;
		n = 0;
		while (resumeIrq !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk(n < 100, 1'b1, "interrupt processing entered");
		@(posedge clk_sys);
		chk(cpuClkEn, 1'b1, "cpu running again");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole run needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		foreach (ROWS[i])
		begin
			if (ROWS[i].we)
			begin
				axw(ROWS[i].a, ROWS[i].d);
				chk(resp, ROWS[i].r, "write response");
			end
			if (!ROWS[i].we || ROWS[i].r == OK)
			begin
				axr(ROWS[i].a);
				chk(resp, ROWS[i].r, "read response");
				if (ROWS[i].r == OK)
					chk(got, ROWS[i].e, "read value");
			end
			if (ROWS[i].a == `LPMC_OFF_MSTPA)
				chk(stopA, ROWS[i].e, "stop A output");
			if (ROWS[i].a == `LPMC_OFF_MSTPB)
				chk(stopB, ROWS[i].e, "stop B output");
			if (ROWS[i].a == `LPMC_OFF_MSTPC)
				chk(stopC, ROWS[i].e, "stop C output");
		end
		$display("test registers done");
		// Mode change: flag up, old mode kept until it settles
		axw(`LPMC_OFF_OPC, {29'h0, `LPMC_OPC_MIDDLE});
		axr(`LPMC_OFF_OPC);
		chk(got[`LPMC_BIT_TFLAG], 1'b1, "flag during change");
		chk(powerMode, `LPMC_OPC_HIGH, "mode held while changing");
		n = 0;
		while (got[`LPMC_BIT_TFLAG] !== 1'b0 && n < 40)
		begin
			axr(`LPMC_OFF_OPC);
			n++;
		end
		chk(got[2:0], `LPMC_OPC_MIDDLE, "mode field");
		chk(powerMode, `LPMC_OPC_MIDDLE, "mode applied");
		axw(`LPMC_OFF_OPC, 32'h5);
		axr(`LPMC_OFF_OPC);
		chk(got[`LPMC_BIT_TFLAG], 1'b0, "illegal code no change");
		chk(powerMode, `LPMC_OPC_MIDDLE, "illegal code ignored");
		$display("test power mode done");
		// Sleep
		enter(32'h0, `LPMC_RST_MSTPC, 32'h1);
		chk(ramClkEn, 1'b1, "ram runs in sleep");
		chk(timerStop, 1'b0, "timers run in sleep");
		chk(oscEn, 5'h1f, "oscillators run in sleep");
		chk(alwaysOnEn, 1'b1, "watchdog runs in sleep");
		chk(powerMode, `LPMC_OPC_MIDDLE, "mode kept in sleep");
		wake();
		$display("test sleep done");
		// Deep sleep
		enter(32'h0, `LPMC_RST_MSTP, 32'h2);
		chk(alwaysOnEn, 1'b1, "detector runs in deep sleep");
		chk(powerMode, `LPMC_OPC_MIDDLE, "mode kept in deep");
		wake();
		$display("test deep sleep done");
		// Software standby
		enter(32'h8000, `LPMC_RST_MSTPC, 32'h3);
		chk(oscEn, 5'h00, "oscillators stopped");
		chk(ramClkEn, 1'b0, "ram stopped in standby");
		chk({busStop, flashStop, timerStop}, 3'h7, "units stopped");
		chk(stopA, 32'hffff_ffff, "peripherals stopped");
		chk(alwaysOnEn, 1'b1, "watchdog runs in standby");
		wake();
		chk(n >= 40, 1'b1, "oscillator restart wait");
		chk(oscEn, 5'h1f, "oscillators restarted");
		chk(stopA, 32'hf9fc_ffff, "stop bits retained");
		$display("test standby done");
		// Dividers: periods 4, 2 and 1 cycles over a 40-cycle window
		axw(`LPMC_OFF_CLKDIV, 32'h13);
		repeat (8) @(posedge clk_sys);
		c0 = 0;
		c1 = 0;
		c2 = 0;
		repeat (40)
		begin
			@(posedge clk_sys);
			c0 += clkEn[0];
			c1 += clkEn[1];
			c2 += clkEn[2];
		end
		chk(c0, 10, "divider 0 rate");
		chk(c1, 20, "divider 1 rate");
		chk(c2, 40, "divider 2 rate");
		chk(clkEn[4:3], 2'h3, "dividers 3 and 4 rate");
		// Byte strobes: only the enabled lane of the word is written
		wstrb <= 4'h2;
		axw(`LPMC_OFF_CLKDIV, 32'hffff_ff00);
		wstrb <= 4'hf;
		axr(`LPMC_OFF_CLKDIV);
		chk(got, 32'h0000_ff13, "strobed write");
		$display("test dividers done");
		// Second reset in mid-run
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(stopA, `LPMC_RST_MSTP, "stop A after reset");
		chk(powerMode, `LPMC_OPC_HIGH, "mode after reset");
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		axr(`LPMC_OFF_MSTPA);
		chk(got, `LPMC_RST_MSTP, "stop A read after reset");
		$display("test reset done");
		report_and_stop();
	end
endmodule // tb_top
